// ### design/lmccr_cfg.svh
// constants of the led matrix common configuration store
// assumes inclusion by bare name from the package and the design files
`ifndef LMCCR_CFG_SVH
`define LMCCR_CFG_SVH
`define LMCCR_WORD_W 48
`define LMCCR_CMD_W 16
// command identifiers on the command link
`define LMCCR_CMD_WR0 16'haa00
`define LMCCR_CMD_WR1 16'haa01
`define LMCCR_CMD_RD0 16'haa60
`define LMCCR_CMD_RD1 16'haa61
`define LMCCR_CMD_SRST 16'haa80
// reset images, writable masks and fixed reserved values
`define LMCCR_RST0 48'h2000_e000_0107
`define LMCCR_MASK0 48'h9ff1_f1ff_f11f
`define LMCCR_FIX0 48'h2000_0000_0000
`define LMCCR_RST1 48'h00e0_0094_a400
`define LMCCR_MASK1 48'h7fff_ffff_ffff
`define LMCCR_FIX1 48'h0000_0000_0000
// first register field positions
`define LMCCR_CHIP_MSB 4
`define LMCCR_CHIP_LSB 0
`define LMCCR_PDC_BIT 8
`define LMCCR_PS_BIT 12
`define LMCCR_PSP_MSB 14
`define LMCCR_PSP_LSB 13
`define LMCCR_LOD_BIT 15
`define LMCCR_SCAN_MSB 21
`define LMCCR_SCAN_LSB 16
`define LMCCR_SUBP_MSB 24
`define LMCCR_SUBP_LSB 22
`define LMCCR_FMOD_BIT 28
`define LMCCR_FMUL_MSB 32
`define LMCCR_FMUL_LSB 29
`define LMCCR_DLYR_MSB 38
`define LMCCR_DLYR_LSB 36
`define LMCCR_DLYG_MSB 41
`define LMCCR_DLYG_LSB 39
`define LMCCR_DLYB_MSB 44
`define LMCCR_DLYB_LSB 42
`define LMCCR_LSD_BIT 47
// second register field positions
`define LMCCR_SEG_MSB 9
`define LMCCR_SEG_LSB 0
`define LMCCR_LGR_MSB 14
`define LMCCR_LGR_LSB 10
`define LMCCR_LGG_MSB 19
`define LMCCR_LGG_LSB 15
`define LMCCR_LGB_MSB 24
`define LMCCR_LGB_LSB 20
`define LMCCR_ENR_MSB 28
`define LMCCR_ENR_LSB 25
`define LMCCR_ENG_MSB 32
`define LMCCR_ENG_LSB 29
`define LMCCR_ENB_MSB 36
`define LMCCR_ENB_LSB 33
`define LMCCR_LSW_MSB 40
`define LMCCR_LSW_LSB 37
`define LMCCR_BLK_MSB 46
`define LMCCR_BLK_LSB 41
// decode constants
`define LMCCR_SEG_LONG_CODE 10'h3ff
`define LMCCR_SEG_LONG_CLKS 11'h400
`define LMCCR_SEG_SHORT_CLKS 11'h080
`define LMCCR_LSW_ZERO_CLKS 9'h02d
`define LMCCR_LSW_STEP_CLKS 9'h01e
`endif

// ### design/lmccr_pkg.sv
// types shared by the configuration store modules
// assumes lmccr_cfg.svh is on the include path
package lmccr_pkg;
	`include "lmccr_cfg.svh"
	// one configuration word
	typedef logic [`LMCCR_WORD_W-1:0] lmccr_word_t;
	// command identifier
	typedef logic [`LMCCR_CMD_W-1:0] lmccr_cmd_id_t;
	// decoded command kind, one-hot
	typedef enum logic [5:0] {
		LMCCR_NONE = 6'h01,
		LMCCR_WR0 = 6'h02,
		LMCCR_WR1 = 6'h04,
		LMCCR_RD0 = 6'h08,
		LMCCR_RD1 = 6'h10,
		LMCCR_SRST = 6'h20
	} lmccr_cmd_t;
endpackage : lmccr_pkg

// ### design/lmccr_word_if.sv
// carrier between the command decoder and one stored word
// assumes lmccr_pkg is compiled first
`timescale 1ns/100ps
interface lmccr_word_if;
	import lmccr_pkg::*;
	logic wr_en; // full image write strobe
	lmccr_word_t wr_data; // image to store
	logic soft_rst; // restore defaults
	lmccr_word_t value; // stored word
	modport store(input wr_en, input wr_data, input soft_rst, output value);
	modport ctrl(output wr_en, output wr_data, output soft_rst, input value);
endinterface : lmccr_word_if

// ### design/lmccr_cfg_word.sv
// one 48-bit configuration word with fixed reserved bits
// assumes strobes come from logic on core_clk
`timescale 1ns/100ps
`include "lmccr_cfg.svh"
module lmccr_cfg_word #(
	parameter lmccr_pkg::lmccr_word_t RESET_VALUE = `LMCCR_RST0,
	parameter lmccr_pkg::lmccr_word_t WRITE_MASK = `LMCCR_MASK0,
	parameter lmccr_pkg::lmccr_word_t FIXED_BITS = `LMCCR_FIX0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	lmccr_word_if.store port
);
	import lmccr_pkg::*;

	// storage: reserved bits take the fixed value on every load
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			port.value <= RESET_VALUE;
		else if (clk_en)
		begin
			if (port.soft_rst)
				port.value <= RESET_VALUE;
			else if (port.wr_en)
				port.value <= (port.wr_data & WRITE_MASK) | FIXED_BITS;
		end
	end

	// reserved bits never leave their fixed value
	a_reserved_bits_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
		(port.value & ~WRITE_MASK) == FIXED_BITS)
		else $error("reserved bits changed");
endmodule : lmccr_cfg_word

// ### design/lmccr_regs.sv
// common configuration store of the led matrix driver
// assumes commands arrive decoded from the serial link, on core_clk
// Notes on behaviour
// - device count field encodes value plus one
// - predischarge enable bit, resets set
// - basic power saving bit, resets clear
// - enhanced saving level field, four modes
// - open led removal enable, resets clear
// - scan line count encodes value plus one
// - subperiods are sixteen times value plus one
// - multiplier range select high or low
// - multiplier ratio value plus one, reset eight
// - red delay, forward pwm only
// - green delay, forward pwm only
// - blue delay, forward pwm only
// - shorted led removal enable, resets clear
// - segment clocks 1024 at 1023, else 128
// - low gray smoothing levels value plus one, reset ten
// - line switch 45 at zero, else thirty times value plus one
`timescale 1ns/100ps
`include "lmccr_cfg.svh"
module lmccr_regs (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire lmccr_pkg::lmccr_cmd_id_t cmd_id,
	input wire lmccr_pkg::lmccr_word_t cmd_data,
	input wire logic forward_pwm_mode,
	output logic rd_valid,
	output lmccr_pkg::lmccr_word_t rd_data,
	output logic [5:0] device_count,
	output logic predischarge_enable,
	output logic power_saving_enable,
	output logic [1:0] enhanced_saving_level,
	output logic open_led_removal_enable,
	output logic [6:0] scan_line_count,
	output logic [7:0] subperiod_count,
	output logic multiplier_range_select,
	output logic [4:0] multiplier_ratio,
	output logic [2:0] red_output_delay,
	output logic [2:0] green_output_delay,
	output logic [2:0] blue_output_delay,
	output logic shorted_led_removal_enable,
	output logic [10:0] segment_clock_count,
	output logic [5:0] red_low_gray_smoothing,
	output logic [5:0] green_low_gray_smoothing,
	output logic [5:0] blue_low_gray_smoothing,
	output logic [3:0] red_low_gray_enhance,
	output logic [3:0] green_low_gray_enhance,
	output logic [3:0] blue_low_gray_enhance,
	output logic [8:0] line_switch_time,
	output logic [5:0] black_field_adjust
);
	import lmccr_pkg::*;

	lmccr_cmd_t cmd_kind; // decoded command
	lmccr_word_t common_config_0; // first word
	lmccr_word_t common_config_1; // second word
	logic [3:0] lsw_code; // line switch field
	logic [8:0] next_line_switch_time; // decoded switch time
	lmccr_word_if w0 ();
	lmccr_word_if w1 ();

	// command decode; unknown identifiers are ignored
	always_comb
	begin
		cmd_kind = LMCCR_NONE;
		if (cmd_valid)
		begin
			if (cmd_id == `LMCCR_CMD_WR0)
				cmd_kind = LMCCR_WR0;
			else if (cmd_id == `LMCCR_CMD_WR1)
				cmd_kind = LMCCR_WR1;
			else if (cmd_id == `LMCCR_CMD_RD0)
				cmd_kind = LMCCR_RD0;
			else if (cmd_id == `LMCCR_CMD_RD1)
				cmd_kind = LMCCR_RD1;
			else if (cmd_id == `LMCCR_CMD_SRST)
				cmd_kind = LMCCR_SRST;
		end
	end

	// whole-image writes; no byte merge, the store forces reserved bits
	assign w0.wr_en = (cmd_kind == LMCCR_WR0);
	assign w1.wr_en = (cmd_kind == LMCCR_WR1);
	assign w0.wr_data = cmd_data;
	assign w1.wr_data = cmd_data;
	assign w0.soft_rst = (cmd_kind == LMCCR_SRST);
	assign w1.soft_rst = (cmd_kind == LMCCR_SRST);
	assign common_config_0 = w0.value;
	assign common_config_1 = w1.value;

	// first word: fixed 01 in bits 46-45, predischarge and ratio set at reset
	lmccr_cfg_word #(
		.RESET_VALUE(`LMCCR_RST0),
		.WRITE_MASK(`LMCCR_MASK0),
		.FIXED_BITS(`LMCCR_FIX0)
	) u_word0 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.port(w0.store)
	);

	// second word: smoothing nine, switch code seven at reset
	lmccr_cfg_word #(
		.RESET_VALUE(`LMCCR_RST1),
		.WRITE_MASK(`LMCCR_MASK1),
		.FIXED_BITS(`LMCCR_FIX1)
	) u_word1 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.port(w1.store)
	);

	// read answer: word captured one cycle after the command
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else if (clk_en)
		begin
			rd_valid <= (cmd_kind == LMCCR_RD0) || (cmd_kind == LMCCR_RD1);
			if (cmd_kind == LMCCR_RD0)
				rd_data <= common_config_0;
			else if (cmd_kind == LMCCR_RD1)
				rd_data <= common_config_1;
		end
	end

	// line switch decode: zero is a special short time
	assign lsw_code = common_config_1[`LMCCR_LSW_MSB:`LMCCR_LSW_LSB];
	always_comb
	begin
		if (lsw_code == 4'h0)
			next_line_switch_time = `LMCCR_LSW_ZERO_CLKS;
		else
			next_line_switch_time = 9'(({5'h00, lsw_code} + 9'h001) * `LMCCR_LSW_STEP_CLKS);
	end

	// first word decoded outputs, one cycle behind the store
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			device_count <= 6'h08;
			predischarge_enable <= 1'b1;
			power_saving_enable <= 1'b0;
			enhanced_saving_level <= 2'h0;
			open_led_removal_enable <= 1'b0;
			scan_line_count <= 7'h01;
			subperiod_count <= 8'h10;
			multiplier_range_select <= 1'b0;
			multiplier_ratio <= 5'h08;
			shorted_led_removal_enable <= 1'b0;
		end
		else if (clk_en)
		begin
			device_count <= {1'b0, common_config_0[`LMCCR_CHIP_MSB:`LMCCR_CHIP_LSB]} + 6'h01;
			predischarge_enable <= common_config_0[`LMCCR_PDC_BIT];
			power_saving_enable <= common_config_0[`LMCCR_PS_BIT];
			enhanced_saving_level <= common_config_0[`LMCCR_PSP_MSB:`LMCCR_PSP_LSB];
			open_led_removal_enable <= common_config_0[`LMCCR_LOD_BIT];
			scan_line_count <= {1'b0, common_config_0[`LMCCR_SCAN_MSB:`LMCCR_SCAN_LSB]}
				+ 7'h01;
			subperiod_count <= {1'b0, common_config_0[`LMCCR_SUBP_MSB:`LMCCR_SUBP_LSB], 4'h0}
				+ 8'h10;
			multiplier_range_select <= common_config_0[`LMCCR_FMOD_BIT];
			multiplier_ratio <= {1'b0, common_config_0[`LMCCR_FMUL_MSB:`LMCCR_FMUL_LSB]}
				+ 5'h01;
			shorted_led_removal_enable <= common_config_0[`LMCCR_LSD_BIT];
		end
	end

	// group delays count only in forward pwm mode
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			red_output_delay <= 3'h0;
			green_output_delay <= 3'h0;
			blue_output_delay <= 3'h0;
		end
		else if (clk_en)
		begin
			red_output_delay <= forward_pwm_mode ?
				common_config_0[`LMCCR_DLYR_MSB:`LMCCR_DLYR_LSB] : 3'h0;
			green_output_delay <= forward_pwm_mode ?
				common_config_0[`LMCCR_DLYG_MSB:`LMCCR_DLYG_LSB] : 3'h0;
			blue_output_delay <= forward_pwm_mode ?
				common_config_0[`LMCCR_DLYB_MSB:`LMCCR_DLYB_LSB] : 3'h0;
		end
	end

	// second word decoded outputs
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			segment_clock_count <= `LMCCR_SEG_SHORT_CLKS;
			red_low_gray_smoothing <= 6'h0a;
			green_low_gray_smoothing <= 6'h0a;
			blue_low_gray_smoothing <= 6'h0a;
			red_low_gray_enhance <= 4'h0;
			green_low_gray_enhance <= 4'h0;
			blue_low_gray_enhance <= 4'h0;
			line_switch_time <= 9'h0f0;
			black_field_adjust <= 6'h00;
		end
		else if (clk_en)
		begin
			// only the all-ones code selects the long segment
			if (common_config_1[`LMCCR_SEG_MSB:`LMCCR_SEG_LSB] == `LMCCR_SEG_LONG_CODE)
				segment_clock_count <= `LMCCR_SEG_LONG_CLKS;
			else
				segment_clock_count <= `LMCCR_SEG_SHORT_CLKS;
			red_low_gray_smoothing <= {1'b0, common_config_1[`LMCCR_LGR_MSB:`LMCCR_LGR_LSB]}
				+ 6'h01;
			green_low_gray_smoothing <= {1'b0, common_config_1[`LMCCR_LGG_MSB:`LMCCR_LGG_LSB]}
				+ 6'h01;
			blue_low_gray_smoothing <= {1'b0, common_config_1[`LMCCR_LGB_MSB:`LMCCR_LGB_LSB]}
				+ 6'h01;
			red_low_gray_enhance <= common_config_1[`LMCCR_ENR_MSB:`LMCCR_ENR_LSB];
			green_low_gray_enhance <= common_config_1[`LMCCR_ENG_MSB:`LMCCR_ENG_LSB];
			blue_low_gray_enhance <= common_config_1[`LMCCR_ENB_MSB:`LMCCR_ENB_LSB];
			line_switch_time <= next_line_switch_time;
			black_field_adjust <= common_config_1[`LMCCR_BLK_MSB:`LMCCR_BLK_LSB];
		end
	end

	// write lands masked with fixed reserved bits
	a_write_word0_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && cmd_kind == LMCCR_WR0) |=>
		common_config_0 == (($past(cmd_data) & `LMCCR_MASK0) | `LMCCR_FIX0))
		else $error("first word write wrong");
	// soft reset restores both defaults
	a_soft_reset_defaults: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && cmd_kind == LMCCR_SRST) |=>
		common_config_0 == `LMCCR_RST0 && common_config_1 == `LMCCR_RST1)
		else $error("soft reset left non-default value");
	// read answer pulse with stored word
	a_read_answer_data: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && cmd_kind == LMCCR_RD1) |=> rd_valid && rd_data == $past(common_config_1))
		else $error("read answer wrong");
	// device count decode
	a_device_count_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> device_count == $past(common_config_0[4:0]) + 1)
		else $error("device count decode wrong");
	// scan line decode
	a_scan_lines_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> scan_line_count == $past(common_config_0[21:16]) + 1)
		else $error("scan line decode wrong");
	// subperiod decode
	a_subperiod_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> subperiod_count == 16 * ($past(common_config_0[24:22]) + 1))
		else $error("subperiod decode wrong");
	// multiplier ratio decode
	a_multiplier_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> multiplier_ratio == $past(common_config_0[32:29]) + 1)
		else $error("multiplier decode wrong");
	// segment length decode
	a_segment_len_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> segment_clock_count == (($past(common_config_1[9:0]) == 1023) ? 1024 : 128))
		else $error("segment length decode wrong");
	// line switch decode
	a_line_switch_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> line_switch_time == (($past(common_config_1[40:37]) == 0) ? 45 :
		30 * ($past(common_config_1[40:37]) + 1)))
		else $error("line switch decode wrong");
	// delays gated outside forward mode
	a_delay_gate_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clk_en && !forward_pwm_mode) |=> red_output_delay == 0 && green_output_delay == 0
		&& blue_output_delay == 0)
		else $error("group delay active outside forward mode");
endmodule : lmccr_regs

// ### sim/lmccr_ctrl_model.sv
// display controller model that issues command words to the store
// assumes a free running core_clk shared with the store
`timescale 1ns/100ps
module lmccr_ctrl_model (
	input wire logic core_clk,
	output logic cmd_valid,
	output lmccr_pkg::lmccr_cmd_id_t cmd_id,
	output lmccr_pkg::lmccr_word_t cmd_data,
	input wire logic rd_valid,
	input wire lmccr_pkg::lmccr_word_t rd_data
);
	import lmccr_pkg::*;
	// idle lines at time zero
	initial
	begin
		cmd_valid = 1'b0;
		cmd_id = '0;
		cmd_data = '0;
	end
	// one whole command word, one cycle long
	task send(input lmccr_cmd_id_t id, input lmccr_word_t d);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_id <= id;
		cmd_data <= d; // full image every time
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		cmd_id <= ~id; // released lines show inverted garbage
		cmd_data <= ~d;
	endtask : send
	// read command, answer taken one cycle after
	task read(input lmccr_cmd_id_t id, output lmccr_word_t d, output logic ok);
		send(id, '0);
		#1;
		ok = rd_valid;
		d = rd_data;
	endtask : read
	// change fields only, keep the rest as read back
	task rmw(input lmccr_cmd_id_t rid, input lmccr_cmd_id_t wid,
		input lmccr_word_t m, input lmccr_word_t v);
		lmccr_word_t d;
		logic ok;
		read(rid, d, ok);
		send(wid, (d & ~m) | (v & m)); // read before modify
	endtask : rmw
endmodule : lmccr_ctrl_model

// ### sim/tb_lmccr_regs.sv
// self-checking bench of the configuration store
// assumes lmccr_pkg and the controller model are compiled first
`timescale 1ns/100ps
`include "lmccr_cfg.svh"
module tb_lmccr_regs;
	import lmccr_pkg::*;
	logic core_clk = 1'b0; // 100 MHz clock
	logic rst_n = 1'b0; // sync reset
	logic clk_en = 1'b1; // state enable
	logic fwd = 1'b1; // forward pwm mode
	logic cmd_valid, rd_valid, ok;
	lmccr_cmd_id_t cmd_id;
	lmccr_word_t cmd_data, rd_data, d, w;
	logic predischarge_enable, power_saving_enable, open_led_removal_enable;
	logic multiplier_range_select, shorted_led_removal_enable;
	logic [1:0] enhanced_saving_level;
	logic [2:0] red_output_delay, green_output_delay, blue_output_delay;
	logic [3:0] red_low_gray_enhance, green_low_gray_enhance, blue_low_gray_enhance;
	logic [4:0] multiplier_ratio;
	logic [5:0] device_count, black_field_adjust;
	logic [5:0] red_low_gray_smoothing, green_low_gray_smoothing, blue_low_gray_smoothing;
	logic [6:0] scan_line_count;
	logic [7:0] subperiod_count;
	logic [8:0] line_switch_time;
	logic [10:0] segment_clock_count;
	int n_fail = 0; // mismatches
	int num_checks = 0; // comparisons
	int cyc = 0; // timeout count
	int seg_c[3] = '{127, 1023, 5}; // segment codes
	int seg_e[3] = '{128, 1024, 128};
	int lsw_c[3] = '{0, 1, 15}; // line switch codes
	int lsw_e[3] = '{45, 60, 480};
	int lg_c[3] = '{0, 15, 31}; // smoothing codes
	lmccr_regs u_dut (.core_clk, .rst_n, .clk_en, .cmd_valid, .cmd_id, .cmd_data,
		.forward_pwm_mode(fwd), .rd_valid, .rd_data, .device_count, .predischarge_enable,
		.power_saving_enable, .enhanced_saving_level, .open_led_removal_enable,
		.scan_line_count, .subperiod_count, .multiplier_range_select, .multiplier_ratio,
		.red_output_delay, .green_output_delay, .blue_output_delay,
		.shorted_led_removal_enable, .segment_clock_count, .red_low_gray_smoothing,
		.green_low_gray_smoothing, .blue_low_gray_smoothing, .red_low_gray_enhance,
		.green_low_gray_enhance, .blue_low_gray_enhance, .line_switch_time,
		.black_field_adjust);
	lmccr_ctrl_model u_ctrl (.core_clk, .cmd_valid, .cmd_id, .cmd_data, .rd_valid, .rd_data);
	// clock
	always #5 core_clk = ~core_clk;
	// hang guard
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			$display("BAD %0t timeout", $time);
			results;
		end
	end
	// one compare
	task chk(input lmccr_word_t g, input lmccr_word_t e, input string m);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	// write then let decoded outputs follow
	task wr(input lmccr_cmd_id_t id, input lmccr_word_t v);
		u_ctrl.send(id, v);
		@(posedge core_clk);
		#1;
	endtask : wr
	// read and compare
	task rd(input lmccr_cmd_id_t id, input lmccr_word_t e, input string m);
		u_ctrl.read(id, d, ok);
		chk(ok, 1, "valid");
		chk(d, e, m);
		// answer strobe stands one cycle only
		@(posedge core_clk);
		#1;
		chk(rd_valid, 0, "pulse");
	endtask : rd
	// verdict
	task results;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// test sequence
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`LMCCR_CMD_RD0, 48'h2000_e000_0107, "rst0");
		rd(`LMCCR_CMD_RD1, 48'h00e0_0094_a400, "rst1");
		chk(device_count, 8, "dev");
		chk(predischarge_enable, 1, "pdc");
		chk(power_saving_enable, 0, "ps");
		chk(scan_line_count, 1, "scan");
		chk(subperiod_count, 16, "sub");
		chk(multiplier_ratio, 8, "mul");
		chk(segment_clock_count, 128, "seg");
		chk(line_switch_time, 240, "lsw");
		$display("test reset done");
		wr(`LMCCR_CMD_WR0, '1);
		rd(`LMCCR_CMD_RD0, 48'hbff1_f1ff_f11f, "ones");
		chk(device_count, 32, "dev");
		chk(power_saving_enable, 1, "ps");
		chk(open_led_removal_enable, 1, "lod");
		chk(scan_line_count, 64, "scan");
		chk(multiplier_range_select, 1, "rng");
		chk(multiplier_ratio, 16, "mul");
		chk(green_output_delay, 7, "dg");
		chk(blue_output_delay, 7, "db");
		chk(shorted_led_removal_enable, 1, "lsd");
		wr(`LMCCR_CMD_WR0, '0);
		wr(16'haa02, '1);
		rd(`LMCCR_CMD_RD0, 48'h2000_0000_0000, "zero");
		chk(device_count, 1, "dev");
		chk(predischarge_enable, 0, "pdc");
		chk(multiplier_ratio, 1, "mul");
		chk(multiplier_range_select, 0, "rng");
		$display("test word0 done");
		for (int i = 0; i < 8; i++)
		begin
			@(posedge core_clk);
			fwd <= i[0];
			u_ctrl.rmw(`LMCCR_CMD_RD0, `LMCCR_CMD_WR0, 48'h0070_01c0_6000,
				(48'(i) << 36) | (48'(i) << 22) | (48'(i % 4) << 13));
			@(posedge core_clk);
			#1;
			chk(subperiod_count, 16 * (i + 1), "sub");
			chk(enhanced_saving_level, i % 4, "esl");
			chk(red_output_delay, i[0] ? i : 0, "dr");
		end
		$display("test fields done");
		for (int j = 0; j < 3; j++)
		begin
			w = 48'h8000_0000_0000 | 48'(seg_c[j]) | (48'(lsw_c[j]) << 37) | (48'(lg_c[j]) << 10)
				| (48'(lg_c[j]) << 15) | (48'(lg_c[j]) << 20) | (48'(j + 1) << 25)
				| (48'(j + 5) << 29) | (48'(j + 12) << 33) | (48'(j + 40) << 41);
			wr(`LMCCR_CMD_WR1, w);
			rd(`LMCCR_CMD_RD1, w & 48'h7fff_ffff_ffff, "rb1");
			chk(segment_clock_count, seg_e[j], "seg");
			chk(line_switch_time, lsw_e[j], "lsw");
			chk(red_low_gray_smoothing, lg_c[j] + 1, "lg");
			chk(green_low_gray_smoothing, lg_c[j] + 1, "lgg");
			chk(blue_low_gray_smoothing, lg_c[j] + 1, "lgb");
			chk(red_low_gray_enhance, j + 1, "enr");
			chk(green_low_gray_enhance, j + 5, "eng");
			chk(blue_low_gray_enhance, j + 12, "enb");
			chk(black_field_adjust, j + 40, "blk");
		end
		$display("test word1 done");
		@(posedge core_clk);
		clk_en <= 1'b0;
		u_ctrl.send(`LMCCR_CMD_WR0, '1);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd(`LMCCR_CMD_RD0, 48'h2070_01c0_6000, "frz");
		wr(`LMCCR_CMD_SRST, '0);
		rd(`LMCCR_CMD_RD0, 48'h2000_e000_0107, "srst0");
		rd(`LMCCR_CMD_RD1, 48'h00e0_0094_a400, "srst1");
		chk(device_count, 8, "dev");
		$display("test soft reset done");
		results;
	end
endmodule : tb_lmccr_regs
